// file: include/assm_defines.svh
// Constants for the audio service select and mix link
`ifndef ASSM_DEFINES_SVH
`define ASSM_DEFINES_SVH

// Service type codes carried in the 3-bit type field
`define ASSM_SVC_MN       3'h0
`define ASSM_SVC_MX       3'h1
`define ASSM_SVC_NR       3'h2
`define ASSM_SVC_HA       3'h3
`define ASSM_SVC_D        3'h4
`define ASSM_SVC_C        3'h5
`define ASSM_SVC_E        3'h6
`define ASSM_SVC_VX       3'h7

// Field widths
`define ASSM_ID_W         4
`define ASSM_RATE_W       10
`define ASSM_LANG_W       8
`define ASSM_SMP_W        16
`define ASSM_DRC_W        5
`define ASSM_CH_W         3

// Rate limits in kbps
`define ASSM_RATE_MIN     10'h020
`define ASSM_RATE_MAX     10'h280
`define ASSM_RATE_FULL    10'h1C0
`define ASSM_RATE_MONO    10'h080
`define ASSM_RATE_DUAL    10'h0C0
`define ASSM_RATE_SUM     11'h240

// Channel indices and counts
`define ASSM_CH_L         3'h0
`define ASSM_CH_C         3'h1
`define ASSM_CH_R         3'h2
`define ASSM_NCH          6
`define ASSM_CHANS_ONE    3'h1
`define ASSM_CHANS_TWO    3'h2

// Main program attenuation: 6 dB per shift, at most 24 dB
`define ASSM_DRC_MAX      5'h18
`define ASSM_DRC_6DB      5'h06
`define ASSM_DRC_12DB     5'h0C
`define ASSM_DRC_18DB     5'h12
`define ASSM_SHIFT_W      3

// Selection priorities of the associated slot
`define ASSM_PRI_NONE     2'h0
`define ASSM_PRI_USER     2'h1
`define ASSM_PRI_VO       2'h2
`define ASSM_PRI_EMERG    2'h3

// Saturation bounds of the output sample
`define ASSM_SMP_POS      16'h7FFF
`define ASSM_SMP_NEG      16'h8000

`endif

// file: include/assm_if.sv
// Link between the service source and the receiver mixer
`timescale 1ns/10ps
`include "assm_defines.svh"

interface assm_if;
	logic                      desc_valid;
	logic [`ASSM_ID_W-1:0]     desc_id;
	assm_pkg::assm_svc_t       desc_type;
	logic [`ASSM_CH_W-1:0]     desc_chans;
	logic                      desc_complete;
	logic [`ASSM_RATE_W-1:0]   desc_rate;
	logic [`ASSM_LANG_W-1:0]   desc_lang;
	logic                      desc_active;
	logic                      main_valid;
	logic [`ASSM_CH_W-1:0]     main_chan;
	logic [`ASSM_SMP_W-1:0]    main_smp;
	logic                      assoc_valid;
	logic [`ASSM_CH_W-1:0]     assoc_chan;
	logic [`ASSM_SMP_W-1:0]    assoc_smp;
	logic                      drc_valid;
	logic [`ASSM_DRC_W-1:0]    drc_db;

	modport src (
		output desc_valid, desc_id, desc_type, desc_chans, desc_complete,
		output desc_rate, desc_lang, desc_active,
		output main_valid, main_chan, main_smp,
		output assoc_valid, assoc_chan, assoc_smp, drc_valid, drc_db
	);

	modport rcv (
		input desc_valid, desc_id, desc_type, desc_chans, desc_complete,
		input desc_rate, desc_lang, desc_active,
		input main_valid, main_chan, main_smp,
		input assoc_valid, assoc_chan, assoc_smp, drc_valid, drc_db
	);
endinterface

// file: include/assm_pkg.sv
// Types shared by both ends of the audio service link
`include "assm_defines.svh"

package assm_pkg;

	typedef enum logic [2:0] {
		ASSM_MN = `ASSM_SVC_MN,
		ASSM_MX = `ASSM_SVC_MX,
		ASSM_NR = `ASSM_SVC_NR,
		ASSM_HA = `ASSM_SVC_HA,
		ASSM_D  = `ASSM_SVC_D,
		ASSM_C  = `ASSM_SVC_C,
		ASSM_E  = `ASSM_SVC_E,
		ASSM_VX = `ASSM_SVC_VX
	} assm_svc_t;

	typedef enum logic [3:0] {
		ASSM_MODE_OFF   = 4'b0001,
		ASSM_MODE_ADD   = 4'b0010,
		ASSM_MODE_EMERG = 4'b0100,
		ASSM_MODE_FULL  = 4'b1000
	} assm_mode_t;

endpackage

// file: rtl/assm_receiver.sv
// Receiver end: selects main and associated services and mixes them
//
// Summary of operation
// - Emergency service always wins routing to decoder
// - Emergency mutes main, only emergency reproduced
// - Voice-over second priority, below emergency only
// - Voice-over added to main centre channel
// - Voice-over gain words attenuate main, 24 dB
// - Mono narrative gain words attenuate main, 24 dB
// - Mono commentary gain words attenuate main, 24 dB
// - Complete narrative mix never alters main level
// - Mono dialogue added to music-effects centre
// - Source sends mono dialogue over multichannel
// - Stereo dialogue: left to left, right to right
// - Dialogue by stored language, explicit choice overrides
// - Commentary added to listener-chosen channel
// - Flag commentary presence; listener picks one
// - Main and complete services up to 448 kbps
// - Mono associated service at most 128 kbps
// - Stereo dialogue at most 192 kbps
// - Main plus associated at most 576 kbps
// - Rates outside 32 to 640 kbps invalid
// - Service type decoded from 3-bit field
`timescale 1ns/10ps
`include "assm_defines.svh"

module assm_receiver (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	assm_if.rcv                            link,
	input  wire logic [`ASSM_ID_W-1:0]     main_pick_id,
	input  wire logic [`ASSM_LANG_W-1:0]   lang_pref,
	input  wire logic                      lang_override_en,
	input  wire logic [`ASSM_LANG_W-1:0]   lang_override,
	input  wire logic                      assoc_pick_en,
	input  wire logic [`ASSM_ID_W-1:0]     assoc_pick_id,
	input  wire logic [`ASSM_CH_W-1:0]     comment_target,
	input  wire logic                      comment_avail_clr,
	output logic                           out_valid,
	output logic [`ASSM_CH_W-1:0]          out_chan,
	output logic [`ASSM_SMP_W-1:0]         out_smp,
	output logic                           main_on,
	output assm_pkg::assm_mode_t           assoc_mode,
	output assm_pkg::assm_svc_t            assoc_type,
	output logic [`ASSM_DRC_W-1:0]         main_atten,
	output logic                           comment_avail,
	output logic                           rate_err
);

	logic [`ASSM_ID_W-1:0]   main_id_reg;
	assm_pkg::assm_svc_t     main_type_reg;
	logic [`ASSM_CH_W-1:0]   main_chans_reg;
	logic [`ASSM_ID_W-1:0]   assoc_id_reg;
	logic [`ASSM_CH_W-1:0]   assoc_chans_reg;
	logic [1:0]              assoc_pri_reg;
	logic [`ASSM_SMP_W-1:0]  hold_reg [`ASSM_NCH];

	logic                    rate_ok;
	logic                    full_ok;
	logic                    is_main;
	logic [`ASSM_LANG_W-1:0] lang_want;
	logic [1:0]              cand_pri;
	logic                    take;
	logic                    drop;
	logic                    drc_used;
	logic [`ASSM_SHIFT_W-1:0] shift;
	logic signed [`ASSM_SMP_W-1:0] scaled;
	logic [`ASSM_SMP_W-1:0]  add_term;
	logic [`ASSM_CH_W-1:0]   target;
	logic signed [`ASSM_SMP_W:0] sum;
	logic [`ASSM_SMP_W-1:0]  mix;

	////////////////////////////////////////////////////////////////////////
	// Descriptor qualification
	always_comb begin
		rate_ok = (link.desc_rate >= `ASSM_RATE_MIN) &&
			(link.desc_rate <= `ASSM_RATE_MAX);
		is_main = (link.desc_type == assm_pkg::ASSM_MN) ||
			(link.desc_type == assm_pkg::ASSM_MX);
		full_ok = !(is_main || link.desc_complete) ||
			(link.desc_rate <= `ASSM_RATE_FULL);
		lang_want = lang_override_en ? lang_override : lang_pref;
		cand_pri = `ASSM_PRI_NONE;
		case (link.desc_type)
			assm_pkg::ASSM_E: begin
				cand_pri = `ASSM_PRI_EMERG;
			end
			assm_pkg::ASSM_VX: begin
				cand_pri = `ASSM_PRI_VO;
			end
			assm_pkg::ASSM_D: begin
				if (link.desc_lang == lang_want &&
						main_type_reg == assm_pkg::ASSM_MX) begin
					cand_pri = `ASSM_PRI_USER;
				end
			end
			assm_pkg::ASSM_C, assm_pkg::ASSM_NR, assm_pkg::ASSM_HA: begin
				if (assoc_pick_en && link.desc_id == assoc_pick_id) begin
					cand_pri = `ASSM_PRI_USER;
				end
			end
			default: begin
				cand_pri = `ASSM_PRI_NONE;
			end
		endcase
		take = link.desc_valid && link.desc_active && rate_ok &&
			full_ok && cand_pri != `ASSM_PRI_NONE &&
			cand_pri >= assoc_pri_reg;
		drop = link.desc_valid && !link.desc_active &&
			link.desc_id == assoc_id_reg &&
			assoc_mode != assm_pkg::ASSM_MODE_OFF;
	end

	////////////////////////////////////////////////////////////////////////
	// Main service selection
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			main_on        <= 1'b0;
			main_id_reg    <= '0;
			main_type_reg  <= assm_pkg::ASSM_MN;
			main_chans_reg <= '0;
		end else if (link.desc_valid && is_main &&
				link.desc_id == main_pick_id) begin
			main_on <= link.desc_active && rate_ok && full_ok;
			if (link.desc_active) begin
				main_id_reg    <= link.desc_id;
				main_type_reg  <= link.desc_type;
				main_chans_reg <= link.desc_chans;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Associated slot: one service, ranked by priority
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			assoc_mode      <= assm_pkg::ASSM_MODE_OFF;
			assoc_type      <= assm_pkg::ASSM_MN;
			assoc_id_reg    <= '0;
			assoc_chans_reg <= '0;
			assoc_pri_reg   <= `ASSM_PRI_NONE;
		end else if (take) begin
			assoc_type      <= link.desc_type;
			assoc_id_reg    <= link.desc_id;
			assoc_chans_reg <= link.desc_chans;
			assoc_pri_reg   <= cand_pri;
			if (link.desc_type == assm_pkg::ASSM_E) begin
				assoc_mode <= assm_pkg::ASSM_MODE_EMERG;
			end else if (link.desc_complete &&
					link.desc_type != assm_pkg::ASSM_VX) begin
				assoc_mode <= assm_pkg::ASSM_MODE_FULL;
			end else begin
				assoc_mode <= assm_pkg::ASSM_MODE_ADD;
			end
		end else if (drop) begin
			assoc_mode    <= assm_pkg::ASSM_MODE_OFF;
			assoc_pri_reg <= `ASSM_PRI_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main attenuation from the associated gain words, capped at 24 dB
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			main_atten <= '0;
		end else if (take || drop) begin
			main_atten <= '0;
		end else if (link.drc_valid) begin
			main_atten <= (link.drc_db > `ASSM_DRC_MAX) ?
				`ASSM_DRC_MAX : link.drc_db;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latest associated sample per channel
	generate
		for (genvar i = 0; i < `ASSM_NCH; i++) begin : g_hold
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					hold_reg[i] <= '0;
				end else if (take) begin
					hold_reg[i] <= '0;
				end else if (link.assoc_valid &&
						link.assoc_chan == `ASSM_CH_W'(i)) begin
					hold_reg[i] <= link.assoc_smp;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Mixer datapath
	always_comb begin
		drc_used = (assoc_mode == assm_pkg::ASSM_MODE_ADD) &&
			(assoc_type == assm_pkg::ASSM_VX ||
			assoc_type == assm_pkg::ASSM_NR ||
			assoc_type == assm_pkg::ASSM_C);
		if (!drc_used) begin
			shift = '0;
		end else if (main_atten >= `ASSM_DRC_MAX) begin
			shift = `ASSM_SHIFT_W'(4);
		end else if (main_atten >= `ASSM_DRC_18DB) begin
			shift = `ASSM_SHIFT_W'(3);
		end else if (main_atten >= `ASSM_DRC_12DB) begin
			shift = `ASSM_SHIFT_W'(2);
		end else if (main_atten >= `ASSM_DRC_6DB) begin
			shift = `ASSM_SHIFT_W'(1);
		end else begin
			shift = '0;
		end
		scaled = $signed(link.main_smp) >>> shift;
		if (assoc_type == assm_pkg::ASSM_C ||
				assoc_type == assm_pkg::ASSM_NR) begin
			target = comment_target;
		end else begin
			target = `ASSM_CH_C;
		end
		add_term = '0;
		if (assoc_type == assm_pkg::ASSM_D &&
				assoc_chans_reg == `ASSM_CHANS_TWO &&
				main_chans_reg == `ASSM_CHANS_TWO) begin
			if (link.main_chan == `ASSM_CH_L ||
					link.main_chan == `ASSM_CH_R) begin
				add_term = hold_reg[link.main_chan];
			end
		end else if (link.main_chan == target) begin
			add_term = hold_reg[`ASSM_CH_C];
		end
		sum = {scaled[`ASSM_SMP_W-1], scaled} +
			{add_term[`ASSM_SMP_W-1], add_term};
		if (sum[`ASSM_SMP_W] != sum[`ASSM_SMP_W-1]) begin
			mix = sum[`ASSM_SMP_W] ? `ASSM_SMP_NEG : `ASSM_SMP_POS;
		end else begin
			mix = sum[`ASSM_SMP_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output samples, timed by the main stream
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_chan  <= '0;
			out_smp   <= '0;
		end else begin
			out_valid <= link.main_valid &&
				(main_on || assoc_mode == assm_pkg::ASSM_MODE_EMERG);
			out_chan  <= link.main_chan;
			case (assoc_mode)
				assm_pkg::ASSM_MODE_EMERG: begin
					out_smp <= (link.main_chan == `ASSM_CH_C) ?
						hold_reg[`ASSM_CH_C] : '0;
				end
				assm_pkg::ASSM_MODE_FULL: begin
					out_smp <= hold_reg[link.main_chan];
				end
				assm_pkg::ASSM_MODE_ADD: begin
					out_smp <= mix;
				end
				default: begin
					out_smp <= link.main_smp;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comment_avail <= 1'b0;
			rate_err      <= 1'b0;
		end else begin
			rate_err <= link.desc_valid && !rate_ok;
			if (link.desc_valid && link.desc_active && rate_ok &&
					link.desc_type == assm_pkg::ASSM_C) begin
				comment_avail <= 1'b1;
			end else if (comment_avail_clr) begin
				comment_avail <= 1'b0;
			end
		end
	end

endmodule // assm_receiver

// file: rtl/assm_source.sv
// Service source end: checks service limits and drives the link
`timescale 1ns/10ps
`include "assm_defines.svh"

module assm_source (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	assm_if.src                            link,
	input  wire logic                      req_valid,
	input  wire logic [`ASSM_ID_W-1:0]     req_id,
	input  wire assm_pkg::assm_svc_t       req_type,
	input  wire logic [`ASSM_CH_W-1:0]     req_chans,
	input  wire logic                      req_complete,
	input  wire logic [`ASSM_RATE_W-1:0]   req_rate,
	input  wire logic [`ASSM_LANG_W-1:0]   req_lang,
	input  wire logic                      req_active,
	input  wire logic                      main_in_valid,
	input  wire logic [`ASSM_CH_W-1:0]     main_in_chan,
	input  wire logic [`ASSM_SMP_W-1:0]    main_in_smp,
	input  wire logic                      assoc_in_valid,
	input  wire logic [`ASSM_CH_W-1:0]     assoc_in_chan,
	input  wire logic [`ASSM_SMP_W-1:0]    assoc_in_smp,
	input  wire logic                      drc_in_valid,
	input  wire logic [`ASSM_DRC_W-1:0]    drc_in_db,
	output logic                           req_reject
);

	logic [`ASSM_RATE_W-1:0] main_rate_reg;
	logic [`ASSM_CH_W-1:0]   main_chans_reg;
	logic                    is_main;
	logic                    is_full;
	logic                    ok;
	logic [`ASSM_RATE_W:0]   sum;

	////////////////////////////////////////////////////////////////////////
	// Limit checks on each requested service
	always_comb begin
		is_main = (req_type == assm_pkg::ASSM_MN) ||
			(req_type == assm_pkg::ASSM_MX);
		is_full = is_main || req_complete;
		sum = {1'b0, main_rate_reg} + {1'b0, req_rate};
		ok = 1'b1;
		if (is_full) begin
			ok = (req_rate <= `ASSM_RATE_FULL);
		end else begin
			if (req_type == assm_pkg::ASSM_D &&
					req_chans == `ASSM_CHANS_TWO) begin
				ok = (req_rate <= `ASSM_RATE_DUAL);
			end else begin
				ok = (req_rate <= `ASSM_RATE_MONO);
			end
			if (sum > `ASSM_RATE_SUM) begin
				ok = 1'b0;
			end
			if (req_type == assm_pkg::ASSM_D &&
					main_chans_reg > `ASSM_CHANS_TWO &&
					req_chans != `ASSM_CHANS_ONE) begin
				ok = 1'b0;
			end
		end
		if (!req_active) begin
			ok = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main service bookkeeping for the combined-rate check
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			main_rate_reg  <= '0;
			main_chans_reg <= '0;
		end else if (req_valid && is_main && ok) begin
			main_rate_reg  <= req_active ? req_rate : '0;
			main_chans_reg <= req_active ? req_chans : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Descriptor output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link.desc_valid    <= 1'b0;
			link.desc_id       <= '0;
			link.desc_type     <= assm_pkg::ASSM_MN;
			link.desc_chans    <= '0;
			link.desc_complete <= 1'b0;
			link.desc_rate     <= '0;
			link.desc_lang     <= '0;
			link.desc_active   <= 1'b0;
			req_reject         <= 1'b0;
		end else begin
			link.desc_valid <= req_valid && ok;
			req_reject      <= req_valid && !ok;
			if (req_valid && ok) begin
				link.desc_id       <= req_id;
				link.desc_type     <= req_type;
				link.desc_chans    <= req_chans;
				link.desc_complete <= req_complete;
				link.desc_rate     <= req_rate;
				link.desc_lang     <= req_lang;
				link.desc_active   <= req_active;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample and gain word output, one cycle of latency
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link.main_valid  <= 1'b0;
			link.main_chan   <= '0;
			link.main_smp    <= '0;
			link.assoc_valid <= 1'b0;
			link.assoc_chan  <= '0;
			link.assoc_smp   <= '0;
			link.drc_valid   <= 1'b0;
			link.drc_db      <= '0;
		end else begin
			link.main_valid  <= main_in_valid;
			link.main_chan   <= main_in_chan;
			link.main_smp    <= main_in_smp;
			link.assoc_valid <= assoc_in_valid;
			link.assoc_chan  <= assoc_in_chan;
			link.assoc_smp   <= assoc_in_smp;
			link.drc_valid   <= drc_in_valid;
			link.drc_db      <= drc_in_db;
		end
	end

endmodule // assm_source

// file: tb/assm_checker.sv
// Assertions on the service link and the mixer outputs
`timescale 1ns/10ps
`include "assm_defines.svh"

module assm_checker (
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire logic                    desc_valid,
	input wire assm_pkg::assm_svc_t     desc_type,
	input wire logic                    desc_active,
	input wire logic [`ASSM_RATE_W-1:0] desc_rate,
	input wire logic                    main_valid,
	input wire logic [`ASSM_CH_W-1:0]   main_chan,
	input wire logic                    drc_valid,
	input wire logic [`ASSM_DRC_W-1:0]  drc_db,
	input wire logic                    out_valid,
	input wire logic [`ASSM_CH_W-1:0]   out_chan,
	input wire logic [`ASSM_SMP_W-1:0]  out_smp,
	input wire assm_pkg::assm_mode_t    assoc_mode,
	input wire logic [`ASSM_DRC_W-1:0]  main_atten,
	input wire logic                    rate_err
);
	logic rate_ok;
	logic emerg;

	assign rate_ok = desc_rate >= `ASSM_RATE_MIN && desc_rate <= `ASSM_RATE_MAX;
	assign emerg = assoc_mode == assm_pkg::ASSM_MODE_EMERG;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	AST_EMERG_TAKE: assert property (
		desc_valid && desc_active && rate_ok && desc_type == assm_pkg::ASSM_E
		|=> emerg) else $error("emergency service not taken");
	AST_VX_KEEP: assert property (
		emerg && desc_valid && desc_active && desc_type == assm_pkg::ASSM_VX
		|=> emerg) else $error("voice-over displaced emergency");
	AST_EMERG_OUT: assert property (
		main_valid && emerg && !desc_valid
		|=> out_valid && out_chan == $past(main_chan))
		else $error("no output during emergency");
	AST_EMERG_MUTE: assert property (
		main_valid && emerg && !desc_valid && main_chan != `ASSM_CH_C
		|=> out_smp == 16'h0000) else $error("main not muted");
	AST_ATTEN_SAT: assert property (
		drc_valid && !desc_valid |=> main_atten == ($past(drc_db) >
		`ASSM_DRC_MAX ? `ASSM_DRC_MAX : $past(drc_db)))
		else $error("attenuation not taken");
	AST_ATTEN_MAX: assert property (
		main_atten <= `ASSM_DRC_MAX) else $error("attenuation above 24 dB");
	AST_RATE_BAD: assert property (
		desc_valid && desc_active && !rate_ok |=> rate_err)
		else $error("bad rate not flagged");
	AST_RATE_GOOD: assert property (
		desc_valid && rate_ok |=> !rate_err) else $error("good rate flagged");
endmodule // assm_checker

// file: tb/assm_tb_top.sv
// Self-checking testbench for the service source and receiver mixer
`timescale 1ns/10ps
`include "assm_defines.svh"

module assm_tb_top;
	logic                    mclk;
	logic                    rst_n;
	logic                    req_valid;
	logic [3:0]              req_id;
	assm_pkg::assm_svc_t     req_type;
	logic [2:0]              req_chans;
	logic                    req_complete;
	logic [9:0]              req_rate;
	logic [7:0]              req_lang;
	logic                    req_active;
	logic [2:0]              in_valid;
	logic [2:0]              in_chan;
	logic [15:0]             in_smp;
	logic [3:0]              main_pick_id;
	logic [7:0]              lang_override;
	logic                    lang_override_en;
	logic                    assoc_pick_en;
	logic [3:0]              assoc_pick_id;
	logic [2:0]              comment_target;
	logic                    comment_avail_clr;
	logic                    req_reject;
	logic                    out_valid;
	logic [2:0]              out_chan;
	logic [15:0]             out_smp;
	logic                    main_on;
	assm_pkg::assm_mode_t    assoc_mode;
	assm_pkg::assm_svc_t     assoc_type;
	logic [4:0]              main_atten;
	logic                    comment_avail;
	logic                    rate_err;
	logic                    rej;
	logic                    err;
	int                      failures;
	int                      comparisons;
	int                      cycles;

	assm_if i_assm_if ();
	assm_source i_assm_source (.mclk(mclk), .rst_n(rst_n), .link(i_assm_if),
		.req_valid(req_valid), .req_id(req_id), .req_type(req_type),
		.req_chans(req_chans), .req_complete(req_complete),
		.req_rate(req_rate), .req_lang(req_lang), .req_active(req_active),
		.main_in_valid(in_valid[0]), .main_in_chan(in_chan),
		.main_in_smp(in_smp), .assoc_in_valid(in_valid[1]),
		.assoc_in_chan(in_chan), .assoc_in_smp(in_smp),
		.drc_in_valid(in_valid[2]), .drc_in_db(in_smp[4:0]),
		.req_reject(req_reject));
	assm_receiver i_assm_receiver (.mclk(mclk), .rst_n(rst_n),
		.link(i_assm_if), .main_pick_id(main_pick_id), .lang_pref(8'h45),
		.lang_override_en(lang_override_en), .lang_override(lang_override),
		.assoc_pick_en(assoc_pick_en), .assoc_pick_id(assoc_pick_id),
		.comment_target(comment_target),
		.comment_avail_clr(comment_avail_clr), .out_valid(out_valid),
		.out_chan(out_chan), .out_smp(out_smp), .main_on(main_on),
		.assoc_mode(assoc_mode), .assoc_type(assoc_type),
		.main_atten(main_atten), .comment_avail(comment_avail),
		.rate_err(rate_err));
	assm_checker i_assm_checker (.mclk(mclk), .rst_n(rst_n),
		.desc_valid(i_assm_if.desc_valid), .desc_type(i_assm_if.desc_type),
		.desc_active(i_assm_if.desc_active), .desc_rate(i_assm_if.desc_rate),
		.main_valid(i_assm_if.main_valid), .main_chan(i_assm_if.main_chan),
		.drc_valid(i_assm_if.drc_valid), .drc_db(i_assm_if.drc_db),
		.out_valid(out_valid), .out_chan(out_chan), .out_smp(out_smp),
		.assoc_mode(assoc_mode), .main_atten(main_atten),
		.rate_err(rate_err));

	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("Comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk_flag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	// Request, then capture the source answer and the receiver update
	task desc(input logic [3:0] id, input assm_pkg::assm_svc_t ty,
		input logic [2:0] ch, input logic cm, input logic [9:0] rt,
		input logic [7:0] lg, input logic act);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_id <= id;
		req_type <= ty;
		req_chans <= ch;
		req_complete <= cm;
		req_rate <= rt;
		req_lang <= lg;
		req_active <= act;
		@(posedge mclk);
		req_valid <= 1'b0;
		#1 rej = req_reject;
		@(posedge mclk);
		#1 err = rate_err;
	endtask

	// Kind 0 main sample, 1 associated sample, 2 attenuation word
	task feed(input int k, input logic [2:0] ch, input logic [15:0] v);
		@(posedge mclk);
		in_valid <= 3'h1 << k;
		in_chan <= ch;
		in_smp <= v;
		@(posedge mclk);
		in_valid <= 3'h0;
		@(posedge mclk);
		#1;
	endtask

	task play(input logic [2:0] ch, input logic [15:0] v,
		input logic [15:0] exp);
		feed(0, ch, v);
		chk_flag(out_valid, 1'b1);
		chk_val(out_smp, exp);
	endtask

	task mode(input assm_pkg::assm_mode_t m, input assm_pkg::assm_svc_t t);
		chk_val({12'h000, assoc_mode}, {12'h000, m});
		chk_val({13'h0000, assoc_type}, {13'h0000, t});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		{rst_n, req_valid, req_id, req_chans, req_complete} = '0;
		{req_rate, req_lang, req_active, in_valid, in_chan, in_smp} = '0;
		{lang_override, lang_override_en, assoc_pick_en, assoc_pick_id} = '0;
		{comment_target, comment_avail_clr, failures, comparisons} = '0;
		{rej, err} = '0;
		req_type = assm_pkg::ASSM_MN;
		main_pick_id = 4'h1;
		cycles = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		desc(4'h1, assm_pkg::ASSM_MN, 3'h6, 1'b0, 10'h1C1, 8'h45, 1'b1);
		chk_flag(rej, 1'b1);
		desc(4'h1, assm_pkg::ASSM_MN, 3'h6, 1'b0, 10'h1C0, 8'h45, 1'b1);
		chk_flag(main_on, 1'b1);
		play(3'h0, 16'h1234, 16'h1234);
		desc(4'h2, assm_pkg::ASSM_C, 3'h1, 1'b0, 10'h010, 8'h45, 1'b1);
		chk_flag(err, 1'b1);
		desc(4'h3, assm_pkg::ASSM_VX, 3'h1, 1'b0, 10'h081, 8'h45, 1'b1);
		chk_flag(rej, 1'b1);
		desc(4'h3, assm_pkg::ASSM_VX, 3'h1, 1'b0, 10'h080, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_ADD, assm_pkg::ASSM_VX);
		feed(1, 3'h1, 16'h0100);
		feed(2, 3'h0, 16'h000C);
		chk_val({11'h000, main_atten}, 16'h000C);
		play(3'h1, 16'h0400, 16'h0200);
		play(3'h0, 16'h0400, 16'h0100);
		feed(2, 3'h0, 16'h001F);
		play(3'h0, 16'h0400, 16'h0040);
		desc(4'h4, assm_pkg::ASSM_E, 3'h1, 1'b0, 10'h040, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_EMERG, assm_pkg::ASSM_E);
		desc(4'h5, assm_pkg::ASSM_VX, 3'h1, 1'b0, 10'h040, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_EMERG, assm_pkg::ASSM_E);
		feed(1, 3'h1, 16'h0333);
		play(3'h1, 16'h7000, 16'h0333);
		play(3'h0, 16'h7000, 16'h0000);
		desc(4'h4, assm_pkg::ASSM_E, 3'h1, 1'b0, 10'h040, 8'h45, 1'b0);
		mode(assm_pkg::ASSM_MODE_OFF, assm_pkg::ASSM_E);
		desc(4'h1, assm_pkg::ASSM_MX, 3'h2, 1'b0, 10'h1C0, 8'h45, 1'b1);
		desc(4'h6, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h0C0, 8'h45, 1'b1);
		chk_flag(rej, 1'b1);
		desc(4'h1, assm_pkg::ASSM_MX, 3'h2, 1'b0, 10'h0C0, 8'h45, 1'b1);
		desc(4'h6, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h0C1, 8'h45, 1'b1);
		chk_flag(rej, 1'b1);
		desc(4'h6, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h0C0, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_ADD, assm_pkg::ASSM_D);
		feed(1, 3'h0, 16'h0010);
		feed(1, 3'h2, 16'h0020);
		play(3'h0, 16'h0100, 16'h0110);
		play(3'h2, 16'h0100, 16'h0120);
		desc(4'h7, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h0C0, 8'h46, 1'b1);
		play(3'h0, 16'h0100, 16'h0110);
		lang_override <= 8'h46;
		lang_override_en <= 1'b1;
		desc(4'h7, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h0C0, 8'h46, 1'b1);
		play(3'h0, 16'h0100, 16'h0100);
		desc(4'h1, assm_pkg::ASSM_MX, 3'h6, 1'b0, 10'h180, 8'h45, 1'b1);
		desc(4'h8, assm_pkg::ASSM_D, 3'h2, 1'b0, 10'h060, 8'h46, 1'b1);
		chk_flag(rej, 1'b1);
		desc(4'h8, assm_pkg::ASSM_D, 3'h1, 1'b0, 10'h060, 8'h46, 1'b1);
		feed(1, 3'h1, 16'h0011);
		play(3'h1, 16'h0100, 16'h0111);
		desc(4'h1, assm_pkg::ASSM_MN, 3'h6, 1'b0, 10'h180, 8'h45, 1'b1);
		desc(4'h9, assm_pkg::ASSM_C, 3'h1, 1'b0, 10'h060, 8'h45, 1'b1);
		chk_flag(comment_avail, 1'b1);
		mode(assm_pkg::ASSM_MODE_ADD, assm_pkg::ASSM_D);
		comment_avail_clr <= 1'b1;
		@(posedge mclk);
		comment_avail_clr <= 1'b0;
		assoc_pick_en <= 1'b1;
		assoc_pick_id <= 4'h9;
		comment_target <= 3'h2;
		@(posedge mclk);
		#1 chk_flag(comment_avail, 1'b0);
		desc(4'h9, assm_pkg::ASSM_C, 3'h1, 1'b0, 10'h060, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_ADD, assm_pkg::ASSM_C);
		feed(1, 3'h1, 16'h0050);
		feed(2, 3'h0, 16'h0006);
		play(3'h2, 16'h0100, 16'h00D0);
		play(3'h0, 16'h0100, 16'h0080);
		assoc_pick_id <= 4'hA;
		desc(4'hA, assm_pkg::ASSM_NR, 3'h1, 1'b0, 10'h060, 8'h45, 1'b1);
		feed(1, 3'h1, 16'h0050);
		feed(2, 3'h0, 16'h000C);
		play(3'h2, 16'h0100, 16'h0090);
		assoc_pick_id <= 4'hB;
		desc(4'hB, assm_pkg::ASSM_NR, 3'h6, 1'b1, 10'h1C0, 8'h45, 1'b1);
		mode(assm_pkg::ASSM_MODE_FULL, assm_pkg::ASSM_NR);
		feed(1, 3'h0, 16'h0777);
		feed(2, 3'h0, 16'h0018);
		play(3'h0, 16'h0100, 16'h0777);
		wrap_up();
	end
endmodule // assm_tb_top
